// file: lan_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module lan_link_model (
   // clock
   input wire logic clk_in,
   // behaviour chosen by the bench
   input wire logic stall_in,
   input wire logic ack_en_in,
   // link side of the switch
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic msg_valid_in,
   output logic msg_ready_out,
   output logic ack_out,
   // counts for the bench
   output var int beat_cnt_out,
   output var int msg_cnt_out
);
   // -------------------------------------------------------------
   // controller side of one link
   // -------------------------------------------------------------
   logic [1:0] ack_dly_q;
   // stall taken on the rising edge so bench writes never race the answer
   logic stall_q;

   initial begin
      {tx_ready_out, msg_ready_out, ack_out, ack_dly_q} = '0;
      beat_cnt_out = 0;
      msg_cnt_out = 0;
   end

   // take beats and messages; ack comes two edges later when enabled
   always @(posedge clk_in) begin
      if (tx_valid_in && tx_ready_out) beat_cnt_out++;
      if (msg_valid_in && msg_ready_out) msg_cnt_out++;
      ack_dly_q <= {ack_dly_q[0], msg_valid_in && msg_ready_out && ack_en_in};
      stall_q <= stall_in;
   end

   // answers change off the sampling edge, as a real controller would
   always @(negedge clk_in) begin
      tx_ready_out = !stall_q;
      msg_ready_out = 1'h1;
      ack_out = ack_dly_q[1];
   end
endmodule : lan_link_model

`default_nettype wire

// file: link_level_filter.sv
`timescale 1ns/1ps
`default_nettype none

module link_level_filter #(
   parameter int unsigned STABLE_CYCLES = path_switch_pkg::FILTER_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // raw level
   input wire logic level_in,
   // filtered level and its edges
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);

   localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

   generate
      if (STABLE_CYCLES < 1) begin : g_bad
         $error("link_level_filter: STABLE_CYCLES must be at least 1");
      end
   endgenerate

   logic sync1_q, sync2_q, level_q, rise_q, fall_q;
   logic [CW-1:0] cnt_q;
   wire logic differs = sync2_q != level_q;
   wire logic settle = differs && (cnt_q == CW'(STABLE_CYCLES - 1));

   // ----------------------------------------------------------------
   // two-flop synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= path_switch_pkg::RESET_LEVEL;
         sync2_q <= path_switch_pkg::RESET_LEVEL;
      end else begin
         sync1_q <= level_in;
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // stability filter: a glitch restarts the count, so a bouncing
   // reset line never flips the path back and forth
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         level_q <= path_switch_pkg::RESET_LEVEL;
         cnt_q <= '0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         cnt_q <= (differs && !settle) ? cnt_q + CW'(1) : '0; // RULE_13
         if (settle) begin
            level_q <= sync2_q;
         end
         rise_q <= settle && sync2_q;
         fall_q <= settle && !sync2_q;
      end
   end

   assign level_out = level_q;
   assign rise_out = rise_q;
   assign fall_out = fall_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_filter_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE_13
      $changed(level_q) |-> $past(cnt_q) == CW'(STABLE_CYCLES - 1))
      else $error("filtered level moved before the count was reached");

endmodule : link_level_filter

`default_nettype wire

// file: path_switch.sv
// How it works
// RULE_01 - reset low: traffic runs over SMBus
// RULE_02 - after power-on SMBus is the path
// RULE_03 - reset high: move to PCIe
// RULE_04 - SMBus to PCIe: drop unfinished packets
// RULE_05 - resend unacknowledged SMBus message over PCIe
// RULE_06 - reset low: back to SMBus
// RULE_07 - PCIe to SMBus: drop unfinished packets
// RULE_08 - resend unacknowledged PCIe message over SMBus
// RULE_09 - controller decides switch by driving reset
// RULE_10 - drive shared line high before release
// RULE_11 - wait a clock after other owner releases
// RULE_12 - resend on timeout, give up after 32
// RULE_13 - filtered, synchronised reset level steers the switch
`timescale 1ns/1ps
`default_nettype none

module path_switch #(
   parameter int unsigned FILTER_CYCLES = path_switch_pkg::FILTER_CYCLES,
   parameter int unsigned RESEND_CYCLES = path_switch_pkg::RESEND_CYCLES,
   parameter int unsigned MAX_RETRIES = path_switch_pkg::MAX_RETRIES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // link select level from the chipset
   input wire logic link_select_reset_n_in,
   // path status
   output path_switch_pkg::path_type path_out,
   // transmit from the core
   input wire path_switch_pkg::beat_type core_tx_in,
   input wire logic core_tx_valid_in,
   output logic core_tx_ready_out,
   // transmit towards the links
   output path_switch_pkg::beat_type tx_beat_out,
   output logic smb_tx_valid_out,
   output logic pcie_tx_valid_out,
   input wire logic smb_tx_ready_in,
   input wire logic pcie_tx_ready_in,
   output logic tx_abort_out,
   // receive from the links
   input wire path_switch_pkg::beat_type smb_rx_in,
   input wire path_switch_pkg::beat_type pcie_rx_in,
   input wire logic smb_rx_valid_in,
   input wire logic pcie_rx_valid_in,
   output logic smb_rx_ready_out,
   output logic pcie_rx_ready_out,
   // receive towards the core
   output path_switch_pkg::beat_type core_rx_out,
   output logic core_rx_valid_out,
   input wire logic core_rx_ready_in,
   output logic core_rx_abort_out,
   // in-band messages from the core
   input wire path_switch_pkg::msg_type core_msg_in,
   input wire logic core_msg_valid_in,
   output logic core_msg_ready_out,
   output logic msg_done_out,
   output logic msg_giveup_out,
   // in-band messages towards the links
   output path_switch_pkg::msg_type msg_out,
   output logic smb_msg_valid_out,
   output logic pcie_msg_valid_out,
   input wire logic smb_msg_ready_in,
   input wire logic pcie_msg_ready_in,
   input wire logic smb_ack_in,
   input wire logic pcie_ack_in,
   // sustained tri-state shared line
   input wire logic line_claim_in,
   input wire logic line_busy_in,
   output logic line_out,
   output logic line_oe_n_out
);

   localparam int unsigned TW = $clog2(RESEND_CYCLES + 1);
   localparam int unsigned RW = $clog2(MAX_RETRIES + 1);

   generate
      if (RESEND_CYCLES < 1 || MAX_RETRIES < 1) begin : g_bad
         $error("path_switch: RESEND_CYCLES and MAX_RETRIES must be at least 1");
      end
   endgenerate

   // ----------------------------------------------------------------
   // path selection
   // ----------------------------------------------------------------
   logic lvl, lvl_rise, lvl_fall;
   path_switch_pkg::path_type path_q;

   link_level_filter #(
      .STABLE_CYCLES(FILTER_CYCLES)
   ) u_filter (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .level_in(link_select_reset_n_in),
      .level_out(lvl),
      .rise_out(lvl_rise),
      .fall_out(lvl_fall)
   );

   wire logic change = lvl_rise || lvl_fall;
   wire logic on_pcie = path_q == path_switch_pkg::PATH_PCIE;

   // the path only moves on a filtered edge of the reset level
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         path_q <= path_switch_pkg::RESET_PATH; // RULE_02
      end else if (lvl_rise) begin
         path_q <= path_switch_pkg::PATH_PCIE; // RULE_03
      end else if (lvl_fall) begin
         path_q <= path_switch_pkg::PATH_SMBUS; // RULE_06 RULE_01
      end
   end

   assign path_out = path_q;

   // ----------------------------------------------------------------
   // transmit stage
   // ----------------------------------------------------------------
   path_switch_pkg::beat_type tx_q;
   logic tx_vld_q, tx_drop_q, core_open_q, tx_abort_q;

   wire logic tx_out_rdy = on_pcie ? pcie_tx_ready_in : smb_tx_ready_in;
   wire logic tx_fire = tx_vld_q && tx_out_rdy;
   wire logic tx_take = core_tx_valid_in && core_tx_ready_out;
   wire logic core_open_d = tx_take ? !core_tx_in.last : core_open_q;

   // a packet caught mid-way by a changeover is swallowed to its end
   assign core_tx_ready_out = tx_drop_q || !tx_vld_q || tx_out_rdy;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_vld_q <= 1'b0;
         tx_drop_q <= 1'b0;
         core_open_q <= 1'b0;
         tx_abort_q <= 1'b0;
         tx_q <= '0;
      end else begin
         core_open_q <= core_open_d;
         tx_abort_q <= change && (tx_vld_q || core_open_q);
         if (change) begin
            tx_vld_q <= 1'b0; // RULE_04 RULE_07
            tx_drop_q <= core_open_d;
         end else if (tx_drop_q) begin
            tx_drop_q <= !(tx_take && core_tx_in.last);
         end else if (tx_take) begin
            tx_q <= core_tx_in;
            tx_vld_q <= 1'b1;
         end else if (tx_fire) begin
            tx_vld_q <= 1'b0;
         end
      end
   end

   assign tx_beat_out = tx_q;
   assign smb_tx_valid_out = tx_vld_q && !on_pcie;
   assign pcie_tx_valid_out = tx_vld_q && on_pcie;
   assign tx_abort_out = tx_abort_q;

   // ----------------------------------------------------------------
   // receive stage
   // ----------------------------------------------------------------
   path_switch_pkg::beat_type rx_q;
   logic rx_vld_q, rx_hunt_q, rx_open_q, rx_abort_q;

   wire path_switch_pkg::beat_type rx_in = on_pcie ? pcie_rx_in : smb_rx_in;
   wire logic rx_in_vld = on_pcie ? pcie_rx_valid_in : smb_rx_valid_in;
   // while hunting, non-start beats are dropped; a start beat waits for the core
   wire logic rx_rdy = !change && (!rx_vld_q || core_rx_ready_in || (rx_hunt_q && !rx_in.first));
   wire logic rx_take = rx_in_vld && rx_rdy;
   wire logic rx_keep = rx_take && (!rx_hunt_q || rx_in.first);

   assign smb_rx_ready_out = rx_rdy && !on_pcie;
   assign pcie_rx_ready_out = rx_rdy && on_pcie;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_vld_q <= 1'b0;
         rx_hunt_q <= 1'b1;
         rx_open_q <= 1'b0;
         rx_abort_q <= 1'b0;
         rx_q <= '0;
      end else begin
         rx_abort_q <= change && rx_open_q;
         if (change) begin
            rx_vld_q <= 1'b0; // RULE_04 RULE_07
            rx_hunt_q <= 1'b1;
            rx_open_q <= 1'b0;
         end else if (rx_keep) begin
            rx_q <= rx_in;
            rx_vld_q <= 1'b1;
            rx_hunt_q <= rx_in.last;
            rx_open_q <= !rx_in.last;
         end else if (rx_vld_q && core_rx_ready_in) begin
            rx_vld_q <= 1'b0;
         end
      end
   end

   assign core_rx_out = rx_q;
   assign core_rx_valid_out = rx_vld_q;
   assign core_rx_abort_out = rx_abort_q;

   // ----------------------------------------------------------------
   // in-band messages with acknowledge, timeout and retry
   // ----------------------------------------------------------------
   path_switch_pkg::msg_state_type msg_st_q;
   path_switch_pkg::msg_type msg_q;
   logic [TW-1:0] timer_q;
   logic [RW-1:0] retry_q;
   logic done_q, giveup_q;

   wire logic sel_msg_rdy = on_pcie ? pcie_msg_ready_in : smb_msg_ready_in;
   wire logic sel_ack = on_pcie ? pcie_ack_in : smb_ack_in;
   wire logic timeout = timer_q == TW'(RESEND_CYCLES - 1);
   wire logic at_limit = retry_q == RW'(MAX_RETRIES);

   assign core_msg_ready_out = msg_st_q == path_switch_pkg::MSG_IDLE;
   assign smb_msg_valid_out = msg_st_q == path_switch_pkg::MSG_SEND && !on_pcie;
   assign pcie_msg_valid_out = msg_st_q == path_switch_pkg::MSG_SEND && on_pcie;
   assign msg_out = msg_q;
   assign msg_done_out = done_q;
   assign msg_giveup_out = giveup_q;

   // a message still unanswered at a changeover starts afresh on the
   // new path; the retry budget restarts because the old path's
   // misses say nothing about the new one
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         msg_st_q <= path_switch_pkg::MSG_IDLE;
         msg_q <= '0;
         timer_q <= '0;
         retry_q <= '0;
         done_q <= 1'b0;
         giveup_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         giveup_q <= 1'b0;
         unique case (msg_st_q)
            path_switch_pkg::MSG_IDLE: begin
               if (core_msg_valid_in) begin
                  msg_q <= core_msg_in;
                  retry_q <= '0;
                  msg_st_q <= path_switch_pkg::MSG_SEND;
               end
            end
            path_switch_pkg::MSG_SEND: begin
               if (change) begin
                  retry_q <= '0; // RULE_05 RULE_08
               end else if (sel_msg_rdy) begin
                  timer_q <= '0;
                  msg_st_q <= path_switch_pkg::MSG_WAIT;
               end
            end
            path_switch_pkg::MSG_WAIT: begin
               if (change) begin
                  retry_q <= '0; // RULE_05 RULE_08
                  msg_st_q <= path_switch_pkg::MSG_SEND;
               end else if (sel_ack) begin
                  done_q <= 1'b1;
                  msg_st_q <= path_switch_pkg::MSG_IDLE;
               end else if (timeout && at_limit) begin
                  giveup_q <= 1'b1; // RULE_12
                  msg_st_q <= path_switch_pkg::MSG_IDLE;
               end else if (timeout) begin
                  retry_q <= retry_q + RW'(1); // RULE_12
                  msg_st_q <= path_switch_pkg::MSG_SEND;
               end else begin
                  timer_q <= timer_q + TW'(1);
               end
            end
            default: begin
               msg_st_q <= path_switch_pkg::MSG_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sustained tri-state shared line
   // ----------------------------------------------------------------
   path_switch_pkg::line_state_type line_st_q;
   logic busy_q;

   // both samples quiet means the last owner let go a clock ago
   wire logic line_free = !line_busy_in && !busy_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         line_st_q <= path_switch_pkg::LINE_FLOAT;
         busy_q <= 1'b0;
      end else begin
         busy_q <= line_busy_in;
         unique case (line_st_q)
            path_switch_pkg::LINE_FLOAT: begin
               if (line_claim_in && line_free) begin
                  line_st_q <= path_switch_pkg::LINE_LOW; // RULE_11
               end
            end
            path_switch_pkg::LINE_LOW: begin
               if (!line_claim_in) begin
                  line_st_q <= path_switch_pkg::LINE_PARK; // RULE_10
               end
            end
            path_switch_pkg::LINE_PARK: begin
               line_st_q <= path_switch_pkg::LINE_FLOAT;
            end
            default: begin
               line_st_q <= path_switch_pkg::LINE_FLOAT;
            end
         endcase
      end
   end

   // low while owned, high for the single parking clock
   assign line_out = line_st_q != path_switch_pkg::LINE_LOW;
   assign line_oe_n_out = line_st_q == path_switch_pkg::LINE_FLOAT;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   wire logic line_low = line_st_q == path_switch_pkg::LINE_LOW;

   sequence s_release;
      line_low && !line_claim_in;
   endsequence

   sequence s_park_then_float;
      (line_out && !line_oe_n_out) ##1 line_oe_n_out;
   endsequence

   chk_path_after_reset: assert property ($past(!rst_n_in) |-> !on_pcie) // RULE_02
      else $error("path not SMBus after reset");
   chk_rise_to_pcie: assert property (lvl_rise |=> on_pcie) // RULE_03
      else $error("path did not move to PCIe");
   chk_fall_to_smbus: assert property (lvl_fall |=> !on_pcie) // RULE_06
      else $error("path did not move to SMBus");
   chk_level_low_smbus: assert property (!lvl |=> !on_pcie) // RULE_01
      else $error("PCIe used while reset low");
   chk_tx_discard: assert property (change |=> !tx_vld_q && !tx_fire) // RULE_04 RULE_07
      else $error("staged transmit beat survived a changeover");
   chk_rx_discard: assert property (change |=> !rx_vld_q && rx_hunt_q) // RULE_04 RULE_07
      else $error("staged receive beat survived a changeover");
   chk_msg_resend: assert property ( // RULE_05 RULE_08
      (change && msg_st_q == path_switch_pkg::MSG_WAIT)
         |=> msg_st_q == path_switch_pkg::MSG_SEND && retry_q == '0 ##0
             (smb_msg_valid_out != pcie_msg_valid_out))
      else $error("unacknowledged message not resent on new path");
   chk_retry_limit: assert property ( // RULE_12
      (msg_st_q == path_switch_pkg::MSG_WAIT && !change && !sel_ack && timeout && at_limit)
         |=> giveup_q && core_msg_ready_out)
      else $error("message not abandoned after the last retry");
   chk_retry_bound: assert property (retry_q <= RW'(MAX_RETRIES)) // RULE_12
      else $error("retry count passed its limit");
   chk_park_high: assert property (s_release |=> s_park_then_float) // RULE_10
      else $error("shared line not parked high before release");
   chk_wait_free: assert property ( // RULE_11
      $rose(line_low) |-> !$past(line_busy_in) && !$past(line_busy_in, 2))
      else $error("shared line taken too soon after release");

endmodule : path_switch

`default_nettype wire

// file: path_switch_pkg.sv
package path_switch_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   // reset level must sit still this long before the path moves
   localparam int unsigned FILTER_TIME_NS = 1000;
   localparam int unsigned FILTER_CYCLES =
      (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wait for an in-band acknowledge before resending
   localparam int unsigned RESEND_TIME_US = 100;
   localparam int unsigned RESEND_CYCLES = (RESEND_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned MAX_RETRIES = 32;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic first;
      logic last;
      logic [7:0] data;
   } beat_type;

   typedef struct packed {
      logic [7:0] code;
      logic [15:0] body;
   } msg_type;

   // ----------------------------------------------------------------
   // states and reset values
   // ----------------------------------------------------------------
   typedef enum logic {PATH_SMBUS, PATH_PCIE} path_type;
   typedef enum logic [1:0] {MSG_IDLE, MSG_SEND, MSG_WAIT} msg_state_type;
   typedef enum logic [1:0] {LINE_FLOAT, LINE_LOW, LINE_PARK} line_state_type;

   localparam path_type RESET_PATH = PATH_SMBUS;
   localparam logic RESET_LEVEL = 1'b0;

endpackage : path_switch_pkg

// file: smbus_pcie_path_switch_tb.sv
`timescale 1ns/1ps
`default_nettype none

module smbus_pcie_path_switch_tb;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic clk_in, rst_n_in, link_select_reset_n_in;
   path_switch_pkg::path_type path_out;
   path_switch_pkg::beat_type core_tx_in, tx_beat_out, smb_rx_in, pcie_rx_in, core_rx_out;
   path_switch_pkg::msg_type core_msg_in, msg_out;
   logic core_tx_valid_in, core_tx_ready_out, smb_tx_valid_out, pcie_tx_valid_out;
   logic smb_tx_ready_in, pcie_tx_ready_in, tx_abort_out, smb_rx_valid_in, pcie_rx_valid_in;
   logic smb_rx_ready_out, pcie_rx_ready_out, core_rx_valid_out, core_rx_ready_in;
   logic core_rx_abort_out, core_msg_valid_in, core_msg_ready_out, msg_done_out;
   logic msg_giveup_out, smb_msg_valid_out, pcie_msg_valid_out, smb_msg_ready_in;
   logic pcie_msg_ready_in, smb_ack_in, pcie_ack_in, line_claim_in, line_busy_in;
   logic line_out, line_oe_n_out;
   logic smb_stall, pcie_stall, smb_ack_en, pcie_ack_en;
   logic seen_tx_ab, seen_rx_ab, seen_done, seen_gu;
   int smb_beats, pcie_beats, smb_msgs, pcie_msgs;
   int error_cnt = 0;
   int samples_checked = 0;

   // -------------------------------------------------------------
   // design and the two link partners
   // -------------------------------------------------------------
   // short filter and resend wait keep the run small
   path_switch #(.FILTER_CYCLES(3), .RESEND_CYCLES(8), .MAX_RETRIES(32)) u_path_switch (
      .clk_in, .rst_n_in, .link_select_reset_n_in, .path_out, .core_tx_in,
      .core_tx_valid_in, .core_tx_ready_out, .tx_beat_out, .smb_tx_valid_out,
      .pcie_tx_valid_out, .smb_tx_ready_in, .pcie_tx_ready_in, .tx_abort_out,
      .smb_rx_in, .pcie_rx_in, .smb_rx_valid_in, .pcie_rx_valid_in, .smb_rx_ready_out,
      .pcie_rx_ready_out, .core_rx_out, .core_rx_valid_out, .core_rx_ready_in,
      .core_rx_abort_out, .core_msg_in, .core_msg_valid_in, .core_msg_ready_out,
      .msg_done_out, .msg_giveup_out, .msg_out, .smb_msg_valid_out, .pcie_msg_valid_out,
      .smb_msg_ready_in, .pcie_msg_ready_in, .smb_ack_in, .pcie_ack_in,
      .line_claim_in, .line_busy_in, .line_out, .line_oe_n_out);

   lan_link_model u_smb_link (.clk_in(clk_in), .stall_in(smb_stall), .ack_en_in(smb_ack_en),
      .tx_valid_in(smb_tx_valid_out), .tx_ready_out(smb_tx_ready_in),
      .msg_valid_in(smb_msg_valid_out), .msg_ready_out(smb_msg_ready_in),
      .ack_out(smb_ack_in), .beat_cnt_out(smb_beats), .msg_cnt_out(smb_msgs));

   lan_link_model u_pcie_link (.clk_in(clk_in), .stall_in(pcie_stall), .ack_en_in(pcie_ack_en),
      .tx_valid_in(pcie_tx_valid_out), .tx_ready_out(pcie_tx_ready_in),
      .msg_valid_in(pcie_msg_valid_out), .msg_ready_out(pcie_msg_ready_in),
      .ack_out(pcie_ack_in), .beat_cnt_out(pcie_beats), .msg_cnt_out(pcie_msgs));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   initial begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic end_of_test;
      if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc

   // step cycles, latching one-cycle pulses so none slips past
   task automatic run(input int n);
      for (int i = 0; i < n; i++) begin
         cyc(1);
         if (tx_abort_out === 1'h1) seen_tx_ab = 1'h1;
         if (core_rx_abort_out === 1'h1) seen_rx_ab = 1'h1;
         if (msg_done_out === 1'h1) seen_done = 1'h1;
         if (msg_giveup_out === 1'h1) seen_gu = 1'h1;
      end
   endtask : run

   task automatic send_msg(input logic [7:0] code);
      core_msg_in = {code, 16'h5A5A};
      core_msg_valid_in = 1'h1;
      cyc(1);
      core_msg_valid_in = 1'h0;
      {seen_tx_ab, seen_rx_ab, seen_done, seen_gu} = '0;
   endtask : send_msg

   task automatic send_beat(input logic [9:0] b, input logic rx_smb, input logic rx_pcie);
      if (!rx_smb && !rx_pcie) core_tx_in = b;
      smb_rx_in = b;
      pcie_rx_in = b;
      {core_tx_valid_in, smb_rx_valid_in, pcie_rx_valid_in} = {!rx_smb && !rx_pcie, rx_smb, rx_pcie};
      cyc(1);
      {core_tx_valid_in, smb_rx_valid_in, pcie_rx_valid_in} = '0;
   endtask : send_beat

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_smb_traffic;
      send_beat(10'h3A5, 1'h0, 1'h0);
      chk("smb_tx_valid", 1, smb_tx_valid_out);
      chk("pcie_tx_valid", 0, pcie_tx_valid_out);
      chk("tx_beat", 10'h3A5, tx_beat_out);
      send_beat(10'h33C, 1'h1, 1'h0);
      chk("core_rx", 11'h73C, {core_rx_valid_out, core_rx_out});
      chk("smb_beats", 1, smb_beats);
   endtask : t_smb_traffic

   task automatic t_to_pcie;
      smb_stall = 1'h1;
      pcie_ack_en = 1'h1;
      send_beat(10'h277, 1'h0, 1'h0);
      send_msg(8'hD3);
      run(2);
      chk("core_tx_ready", 0, core_tx_ready_out);
      link_select_reset_n_in = 1'h1;
      run(12);
      chk("path", path_switch_pkg::PATH_PCIE, path_out);
      chk("tx_abort", 1, seen_tx_ab);
      chk("smb_tx_valid", 0, smb_tx_valid_out);
      smb_stall = 1'h0;
      send_beat(10'h178, 1'h0, 1'h0);
      run(8);
      chk("pcie_beats", 0, pcie_beats);
      chk("msg_done", 1, seen_done);
      chk("pcie_msgs", 1, pcie_msgs);
      chk("msg_code", 8'hD3, msg_out.code);
      chk("msg_body", 16'h5A5A, msg_out.body);
      chk("path", path_switch_pkg::PATH_PCIE, path_out);
   endtask : t_to_pcie

   task automatic t_to_smb;
      int m0;
      pcie_ack_en = 1'h0;
      smb_ack_en = 1'h1;
      m0 = smb_msgs;
      send_beat(10'h211, 1'h0, 1'h1);
      send_msg(8'hD5);
      run(2);
      link_select_reset_n_in = 1'h0;
      run(24);
      chk("path", path_switch_pkg::PATH_SMBUS, path_out);
      chk("rx_abort", 1, seen_rx_ab);
      chk("tx_abort", 0, seen_tx_ab);
      chk("msg_done", 1, seen_done);
      chk("smb_msgs", 1, smb_msgs - m0);
      send_beat(10'h122, 1'h1, 1'h0);
      chk("core_rx_valid", 0, core_rx_valid_out);
      chk("smb_rx_ready", 1, smb_rx_ready_out);
      core_rx_ready_in = 1'h0;
      send_beat(10'h3C1, 1'h1, 1'h0);
      chk("smb_rx_stall", 0, smb_rx_ready_out);
      chk("pcie_rx_ready", 0, pcie_rx_ready_out);
      send_beat(10'h3C2, 1'h1, 1'h0);
      chk("core_rx_held", 11'h7C1, {core_rx_valid_out, core_rx_out});
      core_rx_ready_in = 1'h1;
   endtask : t_to_smb

   task automatic t_giveup;
      int m0;
      smb_ack_en = 1'h0;
      m0 = smb_msgs;
      send_msg(8'hD3);
      run(600);
      chk("giveup", 1, seen_gu);
      chk("done", 0, seen_done);
      chk("sends", 33, smb_msgs - m0);
      chk("msg_ready", 1, core_msg_ready_out);
   endtask : t_giveup

   task automatic t_shared_line;
      line_busy_in = 1'h1;
      line_claim_in = 1'h1;
      cyc(3);
      chk("oe_busy", 1, line_oe_n_out);
      line_busy_in = 1'h0;
      cyc(1);
      chk("oe_gap", 1, line_oe_n_out);
      cyc(1);
      chk("line_low", 2'h0, {line_out, line_oe_n_out});
      line_claim_in = 1'h0;
      cyc(1);
      chk("line_park", 2'h2, {line_out, line_oe_n_out});
      cyc(1);
      chk("line_float", 1, line_oe_n_out);
   endtask : t_shared_line

   // -------------------------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      {core_tx_valid_in, smb_rx_valid_in, pcie_rx_valid_in, core_msg_valid_in} = '0;
      {line_claim_in, line_busy_in, link_select_reset_n_in, rst_n_in} = '0;
      {smb_stall, pcie_stall, smb_ack_en, pcie_ack_en} = '0;
      {seen_tx_ab, seen_rx_ab, seen_done, seen_gu} = '0;
      {core_tx_in, smb_rx_in, pcie_rx_in, core_msg_in} = '0;
      core_rx_ready_in = 1'h1;
      cyc(8);
      rst_n_in = 1'h1;
      cyc(1);
      chk("path_reset", path_switch_pkg::PATH_SMBUS, path_out);
      chk("oe_reset", 1, line_oe_n_out);
      t_smb_traffic();
      link_select_reset_n_in = 1'h1;
      cyc(2);
      link_select_reset_n_in = 1'h0;
      cyc(10);
      chk("path_glitch", path_switch_pkg::PATH_SMBUS, path_out);
      t_to_pcie();
      t_to_smb();
      t_giveup();
      t_shared_line();
      end_of_test();
   end

   // hang guard: about six times the expected run
   initial begin
      repeat (4000) @(posedge clk_in);
      error_cnt++;
      end_of_test();
   end
endmodule : smbus_pcie_path_switch_tb

`default_nettype wire
